//--- bdp_pkg.sv
// Constants, field layouts and types shared by the byte dot product and
// float-to-integer datapath and its register front end.
// Assumes a single processor clock and a 32-bit APB register bus.

package bdp_pkg;

	// ==========================================================
	// Register map, byte addresses
	localparam int unsigned ADDR_W      = 8;
	localparam logic [7:0]  OFS_SRC1    = 8'h00;
	localparam logic [7:0]  OFS_SRC2    = 8'h04;
	localparam logic [7:0]  OFS_GUARD   = 8'h08;
	localparam logic [7:0]  OFS_ISSUE   = 8'h0C;
	localparam logic [7:0]  OFS_DEST    = 8'h10;
	localparam logic [7:0]  OFS_PSW     = 8'h14;
	localparam logic [7:0]  OFS_STATUS  = 8'h18;

	// ==========================================================
	// Issue word fields
	localparam int unsigned ISS_OP_LSB  = 0;
	localparam int unsigned ISS_OP_W    = 8;
	localparam int unsigned ISS_SLOT_LSB = 8;
	localparam int unsigned ISS_SLOT_W  = 3;
	localparam int unsigned ISS_GUARD_BIT = 11;
	localparam logic [7:0]  OPC_DOT_US  = 8'h5B;
	localparam logic [7:0]  OPC_CVT     = 8'h79;
	localparam logic [7:0]  OPC_CVT_FLG = 8'h7A;
	// Bit n-1 set means slot n may issue the operation.
	localparam logic [4:0]  SLOTS_DSPMUL = 5'h06;
	localparam logic [4:0]  SLOTS_FALU  = 5'h09;
	localparam int unsigned OP_LATENCY  = 3;

	// ==========================================================
	// Processor status word fields
	localparam int unsigned FLAG_W      = 6;
	localparam int unsigned FLAG_INX    = 1;
	localparam int unsigned FLAG_INV    = 4;
	localparam int unsigned FLAG_FTZ    = 5;
	localparam int unsigned RMODE_LSB   = 8;
	localparam logic [5:0]  FLAG_RST    = 6'h00;
	localparam logic [1:0]  RMODE_RST   = 2'h0;
	localparam int unsigned STAT_BUSY   = 0;
	localparam int unsigned STAT_REFUSED = 1;
	localparam logic [31:0] INT_MAX     = 32'h7FFFFFFF;
	localparam logic [31:0] INT_MIN     = 32'h80000000;

	typedef enum logic [1:0] {
		BDP_RM_NEAREST = 2'h0,
		BDP_RM_ZERO    = 2'h1,
		BDP_RM_POS     = 2'h2,
		BDP_RM_NEG     = 2'h3
	} bdp_rmode_t;

	typedef enum logic [2:0] {
		BDP_OP_DOT = 3'h1,
		BDP_OP_CVT = 3'h2,
		BDP_OP_FLG = 3'h4
	} bdp_op_t;

endpackage : bdp_pkg

//--- bdp_dot_unit.sv
// Four-lane unsigned-by-signed byte multiply and sum.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps

module bdp_dot_unit #(
	parameter int LANES = 4
) (
	input  wire logic [8*LANES-1:0] src_u,
	input  wire logic [8*LANES-1:0] src_s,
	output logic      [31:0]        sum
);

	if (LANES < 1 || LANES > 8)
	begin : g_check
		$error("bdp_dot_unit: LANES must be 1 to 8");
	end

	logic signed [16:0] prod [LANES];

	// ==========================================================
	// Lane products
	for (genvar i = 0; i < LANES; i++)
	begin : g_lane
		assign prod[i] = $signed({1'b0, src_u[8*i +: 8]}) * $signed(src_s[8*i +: 8]);
	end

	// ==========================================================
	// Full-precision sum
	always_comb
	begin
		sum = 32'h00000000;
		for (int i = 0; i < LANES; i++)
		begin
			sum = sum + 32'(prod[i]);
		end
	end

endmodule : bdp_dot_unit

//--- bdp_float_to_int.sv
// Single-precision float to signed 32-bit integer with selectable rounding.
// Combinational; also reports the exception vector in status word layout.
`timescale 1ns/1ps

module bdp_float_to_int (
	input  wire logic [31:0] value,
	input  wire logic [1:0]  rmode,
	output logic      [31:0] result,
	output logic      [5:0]  flags
);

	always_comb
	begin
		logic        sgn;
		logic [7:0]  ex;
		logic [22:0] man;
		logic [63:0] q;
		logic [31:0] ipart;
		logic [31:0] mag;
		logic        half;
		logic        rest;
		logic        inc;
		logic        inexact;
		sgn     = value[31];
		ex      = value[30:23];
		man     = value[22:0];
		q       = 64'h0000000000000000;
		ipart   = 32'h00000000;
		mag     = 32'h00000000;
		half    = 1'b0;
		rest    = 1'b0;
		inc     = 1'b0;
		inexact = 1'b0;
		result  = 32'h00000000;
		flags   = bdp_pkg::FLAG_RST;
		if (ex == 8'hFF)
		begin
			flags[bdp_pkg::FLAG_INV] = 1'b1;
			if (man == 23'h000000)
				result = sgn ? bdp_pkg::INT_MIN : bdp_pkg::INT_MAX;
		end
		else if (ex == 8'h00)
		begin
			flags[bdp_pkg::FLAG_FTZ] = (man != 23'h000000);
		end
		else if (ex >= 8'h9E)
		begin
			// Magnitude of two to the 31 or more; only minus two to the 31 fits.
			if (sgn && ex == 8'h9E && man == 23'h000000)
				result = bdp_pkg::INT_MIN;
			else
			begin
				result = sgn ? bdp_pkg::INT_MIN : bdp_pkg::INT_MAX;
				flags[bdp_pkg::FLAG_INV] = 1'b1;
			end
		end
		else
		begin
			if (ex >= 8'h7F)
			begin
				q     = {40'h0000000000, 1'b1, man} << (ex - 8'h76);
				ipart = {1'b0, q[62:32]};
				half  = q[31];
				rest  = |q[30:0];
			end
			else
			begin
				half = (ex == 8'h7E);
				rest = !(ex == 8'h7E && man == 23'h000000);
			end
			inexact = half | rest;
			unique case (bdp_pkg::bdp_rmode_t'(rmode))
				bdp_pkg::BDP_RM_NEAREST: inc = half & (rest | ipart[0]);
				bdp_pkg::BDP_RM_ZERO:    inc = 1'b0;
				bdp_pkg::BDP_RM_POS:     inc = inexact & ~sgn;
				bdp_pkg::BDP_RM_NEG:     inc = inexact & sgn;
			endcase
			mag = ipart + {31'h00000000, inc};
			if (mag[31] && (!sgn || mag[30:0] != 31'h00000000))
			begin
				result = sgn ? bdp_pkg::INT_MIN : bdp_pkg::INT_MAX;
				flags[bdp_pkg::FLAG_INV] = 1'b1;
			end
			else
			begin
				result = sgn ? (32'h00000000 - mag) : mag;
				flags[bdp_pkg::FLAG_INX] = inexact;
			end
		end
	end

endmodule : bdp_float_to_int

//--- bdp_core.sv
// Byte dot product and float-to-integer execution datapath behind an APB slave.
// Assumes an APB master on the same clock; operands, guard and the status
// word are registers, and a write of an allowed opcode and slot to the issue register starts an operation.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps

module bdp_core #(
	parameter int LATENCY = bdp_pkg::OP_LATENCY
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	if (LATENCY < 2 || LATENCY > 8)
	begin : g_check
		$error("bdp_core: LATENCY must be 2 to 8");
	end

	typedef struct packed {
		logic [31:0]               src1;
		logic [31:0]               src2;
		logic [31:0]               guard;
		logic [31:0]               issue_word;
		logic [31:0]               dest;
		logic [5:0]                flags;
		logic [1:0]                rmode;
		logic                      refused;
		logic [LATENCY-1:0]        vld;
		logic [LATENCY-1:0][2:0]   kind;
		logic [LATENCY-1:0]        gd;
		logic [LATENCY-1:0][31:0]  res;
		logic [LATENCY-1:0][5:0]   fl;
		logic                      pready;
		logic                      pslverr;
		logic [31:0]               prdata;
	} bdp_core_state_t;

	localparam bdp_core_state_t ST_RST = '{
		flags:   bdp_pkg::FLAG_RST,
		rmode:   bdp_pkg::RMODE_RST,
		default: '0
	};

	// ==========================================================
	// Reset release
	logic            rst_meta_n;
	logic            rst_sync_n;
	bdp_core_state_t st;
	bdp_core_state_t next_st;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// ==========================================================
	// Decode helpers
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == bdp_pkg::OFS_SRC1)  || (a == bdp_pkg::OFS_SRC2) ||
		              (a == bdp_pkg::OFS_GUARD) || (a == bdp_pkg::OFS_ISSUE) ||
		              (a == bdp_pkg::OFS_DEST)  || (a == bdp_pkg::OFS_PSW) ||
		              (a == bdp_pkg::OFS_STATUS);
	endfunction : addr_mapped

	// Returns the operation kind, or zero when opcode or slot is not allowed.
	function automatic logic [2:0] op_decode(input logic [31:0] w);
		logic [7:0] opc;
		logic [2:0] slot;
		logic [4:0] slot_bit;
		opc      = w[bdp_pkg::ISS_OP_LSB +: bdp_pkg::ISS_OP_W];
		slot     = w[bdp_pkg::ISS_SLOT_LSB +: bdp_pkg::ISS_SLOT_W];
		slot_bit = (slot >= 3'h1 && slot <= 3'h5) ? (5'h01 << (slot - 3'h1)) : 5'h00;
		op_decode = 3'h0;
		if (opc == bdp_pkg::OPC_DOT_US && (slot_bit & bdp_pkg::SLOTS_DSPMUL) != 5'h00)
			op_decode = bdp_pkg::BDP_OP_DOT;
		else if (opc == bdp_pkg::OPC_CVT && (slot_bit & bdp_pkg::SLOTS_FALU) != 5'h00)
			op_decode = bdp_pkg::BDP_OP_CVT;
		else if (opc == bdp_pkg::OPC_CVT_FLG && (slot_bit & bdp_pkg::SLOTS_FALU) != 5'h00)
			op_decode = bdp_pkg::BDP_OP_FLG;
	endfunction : op_decode

	// ==========================================================
	// Execution units
	logic [31:0] dot_sum;
	logic [31:0] cvt_res;
	logic [5:0]  cvt_fl;

	bdp_dot_unit #(
		.LANES (4)
	) u_dot (
		.src_u (st.src1),
		.src_s (st.src2),
		.sum   (dot_sum)
	);

	bdp_float_to_int u_cvt (
		.value  (st.src1),
		.rmode  (st.rmode),
		.result (cvt_res),
		.flags  (cvt_fl)
	);

	// ==========================================================
	// Bus, issue, pipeline and write-back
	logic        acc_first;
	logic        take;
	logic        wr_take;
	logic        issue;
	logic [2:0]  issue_kind;
	logic        issue_guard;
	logic        psw_wr;
	logic        wb_vld;
	logic [2:0]  wb_kind;
	logic [5:0]  flag_upd;

	always_comb
	begin
		next_st     = st;
		acc_first   = psel & penable & ~st.pready;
		take        = psel & penable & st.pready;
		wr_take     = take & pwrite & addr_mapped(paddr);
		issue_kind  = op_decode(pwdata);
		issue       = wr_take && paddr == bdp_pkg::OFS_ISSUE && issue_kind != 3'h0;
		// no guard requested, or else the guard register's low bit
		issue_guard = !pwdata[bdp_pkg::ISS_GUARD_BIT] || st.guard[0];
		psw_wr      = wr_take && paddr == bdp_pkg::OFS_PSW;
		wb_vld      = st.vld[LATENCY-1];
		wb_kind     = st.kind[LATENCY-1];

		// One wait state: data and error are set up in the first access cycle.
		next_st.pready  = acc_first;
		next_st.pslverr = acc_first & ~addr_mapped(paddr);
		if (acc_first)
		begin
			next_st.prdata = 32'h00000000;
			if (!pwrite)
			begin
				unique case (paddr)
					bdp_pkg::OFS_SRC1:   next_st.prdata = st.src1;
					bdp_pkg::OFS_SRC2:   next_st.prdata = st.src2;
					bdp_pkg::OFS_GUARD:  next_st.prdata = st.guard;
					bdp_pkg::OFS_ISSUE:  next_st.prdata = st.issue_word;
					bdp_pkg::OFS_DEST:   next_st.prdata = st.dest;
					bdp_pkg::OFS_PSW:
						next_st.prdata = {22'h000000, st.rmode, 2'h0, st.flags};
					bdp_pkg::OFS_STATUS:
					begin
						next_st.prdata[bdp_pkg::STAT_BUSY]    = |st.vld;
						next_st.prdata[bdp_pkg::STAT_REFUSED] = st.refused;
					end
					default:             next_st.prdata = 32'h00000000;
				endcase
			end
		end

		if (wr_take)
		begin
			unique case (paddr)
				bdp_pkg::OFS_SRC1:  next_st.src1  = pwdata;
				bdp_pkg::OFS_SRC2:  next_st.src2  = pwdata;
				bdp_pkg::OFS_GUARD: next_st.guard = pwdata;
				bdp_pkg::OFS_ISSUE: next_st.issue_word = pwdata;
				bdp_pkg::OFS_PSW:
					next_st.rmode = pwdata[bdp_pkg::RMODE_LSB +: 2];
				default:            next_st.issue_word = st.issue_word;
			endcase
		end

		// Refused issues are sticky until a one is written to the status bit.
		next_st.refused = st.refused;
		if (wr_take && paddr == bdp_pkg::OFS_STATUS && pwdata[bdp_pkg::STAT_REFUSED])
			next_st.refused = 1'b0;
		if (wr_take && paddr == bdp_pkg::OFS_ISSUE && issue_kind == 3'h0)
			next_st.refused = 1'b1;

		// Stage 0 captures the unit outputs; later stages only delay them.
		for (int i = LATENCY - 1; i > 0; i--)
		begin
			next_st.vld[i]  = st.vld[i-1];
			next_st.kind[i] = st.kind[i-1];
			next_st.gd[i]   = st.gd[i-1];
			next_st.res[i]  = st.res[i-1];
			next_st.fl[i]   = st.fl[i-1];
		end
		next_st.vld[0]  = issue;
		next_st.kind[0] = issue_kind;
		next_st.gd[0]   = issue_guard;
		next_st.fl[0]   = cvt_fl;
		unique case (issue_kind)
			bdp_pkg::BDP_OP_DOT: next_st.res[0] = dot_sum;
			bdp_pkg::BDP_OP_CVT: next_st.res[0] = cvt_res;
			// exception vector in status word layout
			bdp_pkg::BDP_OP_FLG: next_st.res[0] = {26'h0000000, cvt_fl};
			default:             next_st.res[0] = 32'h00000000;
		endcase

		if (wb_vld && st.gd[LATENCY-1])
			next_st.dest = st.res[LATENCY-1];

		// only a guarded conversion contributes flags at write-back
		flag_upd = 6'h00;
		if (wb_vld && st.gd[LATENCY-1] && wb_kind == bdp_pkg::BDP_OP_CVT)
			flag_upd = st.fl[LATENCY-1];
		// sticky OR, set wins over explicit write
		next_st.flags = (psw_wr ? pwdata[bdp_pkg::FLAG_W-1:0] : st.flags) | flag_upd;
	end

	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			st <= ST_RST;
		else
			st <= next_st;
	end

	assign prdata  = st.prdata;
	assign pready  = st.pready;
	assign pslverr = st.pslverr;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_sync_n);

	logic src1_denorm;
	assign src1_denorm = st.src1[30:23] == 8'h00 && st.src1[22:0] != 23'h000000;

	logic src1_nan;
	assign src1_nan = st.src1[30:23] == 8'hFF && st.src1[22:0] != 23'h000000;

	// The destination changes LATENCY edges after the issue edge and is sampled one tick later.
	localparam int WB_DLY = LATENCY + 1;

	dot_latency_a: assert property (
		issue && issue_guard && issue_kind == bdp_pkg::BDP_OP_DOT
		|-> ##WB_DLY st.dest == $past(dot_sum, WB_DLY))
		else $error("dot product result wrong or late");

	dot_precision_a: assert property (
		issue && issue_guard && issue_kind == bdp_pkg::BDP_OP_DOT &&
		st.src1 == 32'hFFFFFFFF && st.src2 == 32'h80808080
		|-> ##WB_DLY st.dest == 32'hFFFE0200)
		else $error("dot product lost precision");

	guard_hold_a: assert property (
		issue && !issue_guard |-> ##WB_DLY $stable(st.dest))
		else $error("destination written with false guard");

	cvt_round_a: assert property (
		issue && issue_guard && issue_kind == bdp_pkg::BDP_OP_CVT &&
		st.src1 == 32'h40247AE1 && st.rmode == bdp_pkg::BDP_RM_ZERO
		|-> ##WB_DLY st.dest == 32'h00000002)
		else $error("conversion ignored rounding mode");

	cvt_flush_a: assert property (
		issue && issue_guard && issue_kind == bdp_pkg::BDP_OP_CVT && src1_denorm
		|-> ##WB_DLY st.dest == 32'h00000000 && st.flags[bdp_pkg::FLAG_FTZ])
		else $error("denormal not flushed");

	cvt_flags_a: assert property (
		issue && issue_guard && issue_kind == bdp_pkg::BDP_OP_CVT
		|-> ##WB_DLY (st.dest == $past(cvt_res, WB_DLY)) &&
		        ((st.flags & $past(cvt_fl, WB_DLY)) == $past(cvt_fl, WB_DLY)))
		else $error("conversion flags not set with result");

	flags_sticky_a: assert property (
		!psw_wr |=> (st.flags & $past(st.flags)) == $past(st.flags))
		else $error("status flag cleared without status write");

	cvt_guard_a: assert property (
		wb_vld && !st.gd[LATENCY-1] && !psw_wr |=> $stable(st.flags))
		else $error("flags changed by guarded-off operation");

	flg_keep_a: assert property (
		wb_vld && wb_kind == bdp_pkg::BDP_OP_FLG && !psw_wr |=> $stable(st.flags))
		else $error("flags-only operation changed status flags");

	flg_denorm_a: assert property (
		issue && issue_guard && issue_kind == bdp_pkg::BDP_OP_FLG && src1_denorm
		|-> ##WB_DLY st.dest == 32'h00000020)
		else $error("flags-only denormal vector wrong");

	cvt_inf_a: assert property (
		issue && issue_guard && issue_kind == bdp_pkg::BDP_OP_CVT &&
		st.src1 == 32'h7F800000
		|-> ##WB_DLY st.dest == 32'h7FFFFFFF && st.flags[bdp_pkg::FLAG_INV])
		else $error("infinity not saturated");

	flags_merge_a: assert property (
		psw_wr && flag_upd != 6'h00
		|=> st.flags == ($past(pwdata[5:0]) | $past(flag_upd)))
		else $error("simultaneous flag update lost");

	flg_vector_a: assert property (
		issue && issue_guard && issue_kind == bdp_pkg::BDP_OP_FLG
		|-> ##WB_DLY st.dest == {26'h0000000, $past(cvt_fl, WB_DLY)})
		else $error("flags-only vector not written");

	cvt_nan_a: assert property (
		issue && issue_guard && issue_kind == bdp_pkg::BDP_OP_CVT && src1_nan
		|-> ##WB_DLY st.dest == 32'h00000000 && st.flags[bdp_pkg::FLAG_INV])
		else $error("NaN not converted to zero");

	wb_timing_a: assert property (
		issue |-> ##LATENCY wb_vld)
		else $error("operation not written back on time");

	issue_refused_a: assert property (
		wr_take && paddr == bdp_pkg::OFS_ISSUE && issue_kind == 3'h0 |=> st.refused)
		else $error("bad opcode or slot not refused");

	bus_error_a: assert property (
		psel && penable && !pready && !addr_mapped(paddr) |=> pready && pslverr)
		else $error("unmapped address not flagged");

	apb_answer_a: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("bus answer not one wait state");

endmodule : bdp_core

//--- bdp_apb_master.sv
// APB master standing in for the instruction issue logic and register file.
// Assumes one rising-edge clock shared with the slave it talks to.
`timescale 1ns/1ps

module bdp_apb_master (
	input  wire logic        clock,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial
	begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h00000000;
	end

	// ==========================================================
	// Transfer
	// One transfer; ok stays low when the slave never answers.
	task automatic xfer(
		input  logic        wr,
		input  logic [7:0]  addr,
		input  logic [31:0] wdata,
		output logic [31:0] rdata,
		output logic        err,
		output logic        ok
	);
		int i;
		ok = 1'b0;
		rdata = 32'h00000000;
		err = 1'b0;
		@(posedge clock);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= addr;
		pwdata <= wdata;
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 16 && !ok; i++)
		begin
			@(posedge clock);
			if (pready === 1'b1)
			begin
				ok = 1'b1;
				rdata = prdata;
				err = pslverr;
			end
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		// Released data shows the inverse so a stale word is never mistaken for valid.
		pwdata  <= ~wdata;
	endtask : xfer

	// Two writes back to back: the second setup follows the first answer at once.
	task automatic wr2(
		input  logic [7:0]  addr0,
		input  logic [31:0] data0,
		input  logic [7:0]  addr1,
		input  logic [31:0] data1,
		output logic        ok
	);
		int   i;
		logic done;
		ok   = 1'b0;
		done = 1'b0;
		@(posedge clock);
		psel   <= 1'b1;
		pwrite <= 1'b1;
		paddr  <= addr0;
		pwdata <= data0;
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 16 && !done; i++)
		begin
			@(posedge clock);
			done = (pready === 1'b1);
		end
		penable <= 1'b0;
		paddr   <= addr1;
		pwdata  <= data1;
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 16 && !ok; i++)
		begin
			@(posedge clock);
			ok = done && (pready === 1'b1);
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		pwdata  <= ~data1;
	endtask : wr2
endmodule : bdp_apb_master

//--- bdp_core_tb.sv
// Self-checking bench for the dot product and float conversion datapath.
// Assumes the APB partner model drives the bus and the design holds its assertions.
`timescale 1ns/1ps

`define BDP_CHECK(got, exp) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) \
		begin \
			fails++; \
			$display("mismatch at %0t: got %h expected %h", $time, got, exp); \
		end \
	end

module bdp_core_tb;
	localparam int LAT = 3;
	logic        clock;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	int          fails;
	int          comparisons;
	int          m;
	logic        ok2;
	logic [31:0] pos[4] = '{32'h3, 32'h2, 32'h3, 32'h2};
	logic [31:0] neg[4] = '{32'hFFFFFFFE, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFE};
	logic [31:0] sv_in[6] = '{32'h40400000, 32'hFF4FFFFF, 32'h7F800000,
		32'h00400000, 32'hFFFFFFFF, 32'hFFBFFFFF};
	logic [31:0] sv_dst[6] = '{32'h3, 32'h80000000, 32'h7FFFFFFF, 32'h0, 32'h0, 32'h0};
	logic [31:0] sv_flg[6] = '{32'h00, 32'h10, 32'h10, 32'h20, 32'h10, 32'h10};

	bdp_core #(.LATENCY(LAT)) u_bdp_core (.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	bdp_apb_master u_bdp_apb_master (.clock(clock), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	always #25 clock = ~clock;

	// ==========================================================
	// Tasks
	task automatic results();
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		logic ok;
		u_bdp_apb_master.xfer(w, a, d, r, e, ok);
		if (!ok)
		begin
			fails++;
			$display("mismatch at %0t: no answer from the slave", $time);
			results();
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		bus(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
		logic [31:0] r;
		logic        e;
		bus(1'b0, a, 32'h0, r, e);
		`BDP_CHECK(r, exp)
		`BDP_CHECK(e, eexp)
	endtask : rd

	function automatic logic [31:0] iw(input logic [7:0] opc, input logic [2:0] slot,
		input logic g);
		return {20'h00000, g, slot, opc};
	endfunction : iw

	// Loads operands and guard, issues, waits out the latency, checks results.
	task automatic op(input logic [31:0] w, input logic [31:0] s1, input logic [31:0] s2,
		input logic [31:0] g, input logic [31:0] dst, input logic [31:0] psw);
		wr(bdp_pkg::OFS_SRC1, s1);
		wr(bdp_pkg::OFS_SRC2, s2);
		wr(bdp_pkg::OFS_GUARD, g);
		wr(bdp_pkg::OFS_ISSUE, w);
		repeat (LAT + 1) @(posedge clock);
		rd(bdp_pkg::OFS_DEST, dst, 1'b0);
		rd(bdp_pkg::OFS_PSW, psw, 1'b0);
	endtask : op

	// ==========================================================
	// Sequence
	initial
	begin
		clock = 1'b0;
		rst_n = 1'b0;
		fails = 0;
		comparisons = 0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		rd(bdp_pkg::OFS_PSW, 32'h0, 1'b0);
		rd(8'h1C, 32'h0, 1'b1);
		op(iw(8'h5B, 3'd2, 1'b0), 32'h0A0A1414, 32'h0AFB14F6, 0, 32'hFA, 0);
		op(iw(8'h5B, 3'd3, 1'b1), 32'h9C649C64, 32'h649C649C, 1, 32'h2BC0, 0);
		op(iw(8'h5B, 3'd2, 1'b0), 32'hFFFFFFFF, 32'h80808080, 0, 32'hFFFE0200, 0);
		op(iw(8'h5B, 3'd3, 1'b1), 32'h01010101, 32'h01010101, 0, 32'hFFFE0200, 0);
		op(iw(8'h5B, 3'd1, 1'b0), 32'h01010101, 32'h01010101, 0, 32'hFFFE0200, 0);
		op(iw(8'h79, 3'd2, 1'b0), 32'h40400000, 0, 0, 32'hFFFE0200, 0);
		op(iw(8'h7A, 3'd5, 1'b0), 32'h40400000, 0, 0, 32'hFFFE0200, 0);
		rd(bdp_pkg::OFS_STATUS, 32'h2, 1'b0);
		wr(bdp_pkg::OFS_STATUS, 32'h2);
		rd(bdp_pkg::OFS_STATUS, 32'h0, 1'b0);
		for (m = 0; m < 4; m++)
		begin
			wr(bdp_pkg::OFS_PSW, {22'h0, 2'(m), 8'h00});
			op(iw(8'h79, 3'd1, 1'b0), 32'h40247AE1, 0, 0, pos[m], {22'h0, 2'(m), 8'h02});
			op(iw(8'h79, 3'd4, 1'b0), 32'hBFC147AE, 0, 0, neg[m], {22'h0, 2'(m), 8'h02});
			op(iw(8'h7A, 3'd4, 1'b0), 32'hBFC147AE, 0, 0, 32'h2, {22'h0, 2'(m), 8'h02});
		end
		for (m = 0; m < 6; m++)
		begin
			wr(bdp_pkg::OFS_PSW, 32'h0);
			op(iw(8'h79, 3'd1, 1'b0), sv_in[m], 0, 0, sv_dst[m], sv_flg[m]);
			wr(bdp_pkg::OFS_PSW, 32'h0);
			op(iw(8'h7A, 3'd1, 1'b0), sv_in[m], 0, 0, sv_flg[m], 32'h0);
		end
		wr(bdp_pkg::OFS_PSW, 32'h0);
		op(iw(8'h79, 3'd1, 1'b0), 32'h40247AE1, 0, 0, 32'h3, 32'h02);
		op(iw(8'h79, 3'd4, 1'b0), 32'h7F800000, 0, 0, 32'h7FFFFFFF, 32'h12);
		op(iw(8'h79, 3'd1, 1'b1), 32'h00400000, 0, 0, 32'h7FFFFFFF, 32'h12);
		op(iw(8'h7A, 3'd4, 1'b1), 32'h00400000, 0, 0, 32'h7FFFFFFF, 32'h12);
		op(iw(8'h7A, 3'd1, 1'b1), 32'h00400000, 0, 1, 32'h20, 32'h12);
		op(iw(8'h79, 3'd4, 1'b1), 32'h00400000, 0, 1, 32'h0, 32'h32);
		wr(bdp_pkg::OFS_SRC1, 32'h40247AE1);
		u_bdp_apb_master.wr2(bdp_pkg::OFS_ISSUE, iw(8'h79, 3'd1, 1'b0),
			bdp_pkg::OFS_PSW, 32'h0, ok2);
		`BDP_CHECK(ok2, 1'b1)
		repeat (LAT + 1) @(posedge clock);
		rd(bdp_pkg::OFS_DEST, 32'h3, 1'b0);
		rd(bdp_pkg::OFS_PSW, 32'h02, 1'b0);
		wr(bdp_pkg::OFS_PSW, 32'h0);
		rd(bdp_pkg::OFS_PSW, 32'h0, 1'b0);
		results();
	end
endmodule : bdp_core_tb
